// ==== instr_decode_pkg.sv ====
// constants, classes and carrier types for the instruction word decoder
package instr_decode_pkg;
    // word and field widths
    localparam int WORD_W   = 14;
    localparam int FILE_W   = 7;
    localparam int BIT_W    = 3;
    localparam int LIT_W    = 8;
    localparam int TARGET_W = 11;
    localparam int OP_W     = 4;
    localparam int PHASE_W  = 2;

    // quarter periods of the oscillator per instruction cycle
    localparam int QUARTERS_PER_CYCLE = 4;
    localparam logic [PHASE_W-1:0] PHASE_LAST = 2'h3;
    localparam logic [PHASE_W-1:0] PHASE_FIRST = 2'h0;

    // field positions inside the word
    localparam int TOP_HI     = 13;
    localparam int TOP_LO     = 12;
    localparam int BYTE_OP_HI = 11;
    localparam int BYTE_OP_LO = 8;
    localparam int DEST_POS   = 7;
    localparam int FILE_HI    = 6;
    localparam int BIT_OP_HI  = 11;
    localparam int BIT_OP_LO  = 10;
    localparam int BIT_HI     = 9;
    localparam int BIT_LO     = 7;
    localparam int JUMP_POS   = 11;

    // top two bits of each format
    localparam logic [1:0] TOP_BYTE = 2'h0;
    localparam logic [1:0] TOP_BIT  = 2'h1;
    localparam logic [1:0] TOP_JUMP = 2'h2;
    localparam logic [1:0] TOP_LIT  = 2'h3;

    // selected operation codes
    localparam logic [OP_W-1:0] OP_MISC   = 4'h0;
    localparam logic [OP_W-1:0] OP_DECFSZ = 4'hb;
    localparam logic [OP_W-1:0] OP_INCFSZ = 4'hf;
    localparam logic [1:0]      BOP_SKIPC = 2'h2;
    localparam logic [1:0]      BOP_SKIPS = 2'h3;
    localparam logic [OP_W-1:0] LOP_RETLW = 4'h4;

    // whole words: no-operation, and words that change the program counter without a target
    localparam logic [WORD_W-1:0] WORD_NOP    = 14'h0000;
    localparam logic [WORD_W-1:0] WORD_RETURN = 14'h0008;
    localparam logic [WORD_W-1:0] WORD_RETFIE = 14'h0009;

    // destination select values
    localparam logic DEST_ACC  = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    typedef enum logic [1:0] {
        CLASS_BYTE = 2'b00,
        CLASS_BIT  = 2'b01,
        CLASS_CTRL = 2'b10
    } iclass_e;

    typedef struct packed {
        iclass_e               iclass;
        logic [OP_W-1:0]       opcode;
        logic                  dest;
        logic [FILE_W-1:0]     file_sel;
        logic [BIT_W-1:0]      bit_sel;
        logic [LIT_W-1:0]      literal;
        logic [TARGET_W-1:0]   target;
        logic                  is_jump;
        logic                  pc_change;
        logic                  is_skip;
        logic                  forced_nop;
        logic [WORD_W-1:0]     word;
    } decoded_s;

    localparam decoded_s DECODED_RESET = '0;
endpackage : instr_decode_pkg

// ==== quarter_sequencer.sv ====
// four-period instruction cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module quarter_sequencer
(
    input  wire logic                                 clk,
    input  wire logic                                 rst,
    output logic [instr_decode_pkg::PHASE_W-1:0]      phase,
    output logic                                      cycle_end
);
    import instr_decode_pkg::*;

    logic [PHASE_W-1:0] next_phase;

    // phase wraps after the last quarter
    always_comb
    begin
        next_phase = (phase == PHASE_LAST) ? PHASE_FIRST : phase + 2'h1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            phase <= PHASE_FIRST;
        else
            phase <= next_phase;
    end

    assign cycle_end = (phase == PHASE_LAST);
endmodule : quarter_sequencer
`default_nettype wire

// ==== instr_word_decoder.sv ====
// instruction word decoder with two-cycle sequencing
//
// Contract
// - every instruction is one 14-bit word
// - sort words into byte, bit, control classes
// - destination 0 to accumulator, 1 to file
// - file selector spans 0x00 to 0x7f
// - bit select picks one of eight bits
// - extract 8-bit literal or 11-bit target
// - don't-care bits ignored, either value accepted
// - one cycle, two on skip or jump
// - instruction cycle is four clock periods
// - byte format: 00, op, dest, file
// - bit format: 01, op, bit, file
// - literal format: 11, op, literal byte
`timescale 1ns/1ps
`default_nettype none
module instr_word_decoder
(
    input  wire logic                                MCLK,
    input  wire logic                                RST,
    input  wire logic [instr_decode_pkg::WORD_W-1:0] INSTR_WORD,
    input  wire logic                                SKIP_TRUE,
    output instr_decode_pkg::decoded_s               DECODED,
    output logic [instr_decode_pkg::PHASE_W-1:0]     CYCLE_PHASE,
    output logic                                     CYCLE_END,
    output logic                                     PREFETCH_DISCARD
);
    import instr_decode_pkg::*;

    decoded_s           decoded;
    decoded_s           next_decoded;
    decoded_s           fresh;
    logic [PHASE_W-1:0] phase;
    logic               cycle_end;
    logic               two_cycle;

    // quarter period sequencer
    quarter_sequencer u_seq
    (
        .clk       (MCLK),
        .rst       (RST),
        .phase     (phase),
        .cycle_end (cycle_end)
    );

    // clears the don't-care positions of a literal operation code
    function automatic logic [OP_W-1:0] lit_op(input logic [OP_W-1:0] op);
        logic [OP_W-1:0] r;
        r = op;
        if (op[3:1] == 3'h7)
            r = 4'he;
        else if (op[3:2] == 2'h0)
            r = 4'h0;
        else if (op[3:2] == 2'h1)
            r = 4'h4;
        else if (op[3:1] == 3'h6)
            r = 4'hc;
        return r;
    endfunction : lit_op

    // splits the fetched word into its fields
    always_comb
    begin
        fresh = DECODED_RESET;
        fresh.word     = INSTR_WORD;
        fresh.file_sel = INSTR_WORD[FILE_HI:0];
        unique case (INSTR_WORD[TOP_HI:TOP_LO])
            TOP_BYTE:
            begin
                fresh.opcode = INSTR_WORD[BYTE_OP_HI:BYTE_OP_LO];
                fresh.dest   = INSTR_WORD[DEST_POS];
                // misc words without a destination are control
                if (fresh.opcode == OP_MISC && !INSTR_WORD[DEST_POS])
                    fresh.iclass = CLASS_CTRL;
                else
                    fresh.iclass = CLASS_BYTE;
                fresh.is_skip   = (fresh.opcode == OP_DECFSZ) ||
                                  (fresh.opcode == OP_INCFSZ);
                fresh.pc_change = (INSTR_WORD == WORD_RETURN) ||
                                  (INSTR_WORD == WORD_RETFIE);
            end
            TOP_BIT:
            begin
                fresh.iclass  = CLASS_BIT;
                fresh.opcode  = {2'h0, INSTR_WORD[BIT_OP_HI:BIT_OP_LO]};
                fresh.bit_sel = INSTR_WORD[BIT_HI:BIT_LO];
                fresh.is_skip = (INSTR_WORD[BIT_OP_HI:BIT_OP_LO] == BOP_SKIPC) ||
                                (INSTR_WORD[BIT_OP_HI:BIT_OP_LO] == BOP_SKIPS);
            end
            TOP_JUMP:
            begin
                fresh.iclass    = CLASS_CTRL;
                fresh.is_jump   = 1'b1;
                fresh.opcode    = {3'h0, INSTR_WORD[JUMP_POS]};
                fresh.target    = INSTR_WORD[TARGET_W-1:0];
                fresh.pc_change = 1'b1;
            end
            TOP_LIT:
            begin
                fresh.iclass    = CLASS_CTRL;
                fresh.opcode    = lit_op(INSTR_WORD[BYTE_OP_HI:BYTE_OP_LO]);
                fresh.literal   = INSTR_WORD[LIT_W-1:0];
                fresh.pc_change = (fresh.opcode == LOP_RETLW);
            end
        endcase
        if (fresh.iclass == CLASS_CTRL)
            fresh.file_sel = '0;
    end

    // two cycles on taken skip or branch
    assign two_cycle = decoded.pc_change || (decoded.is_skip && SKIP_TRUE);

    // loads the next instruction, or a forced no-operation after a two-cycle one, at the last quarter of each cycle
    always_comb
    begin
        next_decoded = decoded;
        if (cycle_end)
        begin
            if (two_cycle && !decoded.forced_nop)
            begin
                next_decoded            = DECODED_RESET;
                next_decoded.iclass     = CLASS_CTRL;
                next_decoded.word       = WORD_NOP;
                next_decoded.forced_nop = 1'b1;
            end
            else
                next_decoded = fresh;
        end
    end

    // decoded instruction register
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            decoded <= DECODED_RESET;
        else
            decoded <= next_decoded;
    end

    assign DECODED          = decoded;
    assign CYCLE_PHASE      = phase;
    assign CYCLE_END        = cycle_end;
    // prefetched word is dropped at this cycle end
    assign PREFETCH_DISCARD = cycle_end && two_cycle && !decoded.forced_nop;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    sequence end_seen;
        cycle_end;
    endsequence

    sequence gap_of_three;
        !cycle_end [*3];
    endsequence

    cycle_length_a: assert property (end_seen |=> gap_of_three ##1 cycle_end)
        else $error("instruction cycle is not four periods");

    // the edge right after reset release still sees the reset phase
    phase_step_a: assert property (!$past(RST) && $past(phase) != PHASE_LAST |->
                                   phase == $past(phase) + 2'h1)
        else $error("phase did not advance by one");

    // forced no-operation follows a taken branch
    branch_nop_a: assert property (cycle_end && two_cycle && !decoded.forced_nop |=>
                                   (decoded.forced_nop && decoded.word == WORD_NOP) [*4])
        else $error("no-operation missing after two-cycle instruction");

    single_cycle_a: assert property (cycle_end && !two_cycle |=> !decoded.forced_nop)
        else $error("single-cycle instruction took two cycles");

    dest_field_a: assert property (cycle_end && !two_cycle && INSTR_WORD[TOP_HI:TOP_LO] == TOP_BYTE
                                   |=> decoded.dest == $past(INSTR_WORD[DEST_POS]))
        else $error("destination select not taken from word");

    bit_field_a: assert property (decoded.iclass == CLASS_BIT |->
                                  decoded.bit_sel == decoded.word[BIT_HI:BIT_LO]
                                  && decoded.file_sel == decoded.word[FILE_HI:0])
        else $error("bit or file selector wrong");

    // fixed operation bits kept, don't-care bits cleared
    literal_field_a: assert property (decoded.word[TOP_HI:TOP_LO] == TOP_LIT |->
                                      decoded.literal == decoded.word[LIT_W-1:0]
                                      && decoded.opcode[3:2] == decoded.word[BYTE_OP_HI:BIT_OP_LO]
                                      && decoded.opcode inside {4'h0, 4'h4, 4'h8, 4'h9,
                                                                4'ha, 4'hb, 4'hc, 4'he})
        else $error("literal field or don't-care mask wrong");

    jump_target_a: assert property (decoded.is_jump |-> decoded.pc_change
                                    && decoded.target == decoded.word[TARGET_W-1:0])
        else $error("jump target wrong");

    class_hold_a: assert property (!$past(cycle_end) |-> $stable(decoded))
        else $error("decode changed inside an instruction cycle");

    class_code_a: assert property (decoded.word[TOP_HI:TOP_LO] != TOP_BYTE |->
                                   decoded.iclass == (decoded.word[TOP_HI] ? CLASS_CTRL : CLASS_BIT))
        else $error("class does not follow the top bits");

    byte_format_a: assert property (decoded.iclass == CLASS_BYTE |->
                                    decoded.opcode == decoded.word[BYTE_OP_HI:BYTE_OP_LO]
                                    && decoded.dest == decoded.word[DEST_POS]
                                    && decoded.file_sel == decoded.word[FILE_HI:0])
        else $error("byte format fields wrong");

    bit_format_a: assert property (decoded.iclass == CLASS_BIT |->
                                   decoded.opcode == {2'h0, decoded.word[BIT_OP_HI:BIT_OP_LO]})
        else $error("bit operation code wrong");

    nop_once_a: assert property (cycle_end && decoded.forced_nop |=> !decoded.forced_nop)
        else $error("forced no-operation repeated");
endmodule : instr_word_decoder
`default_nettype wire

// ==== prog_fetch_model.sv ====
// fetch path model: one program word per instruction cycle
`timescale 1ns/1ps
`default_nettype none
module prog_fetch_model
(
    input  wire logic                                clk,
    input  wire logic                                rst,
    input  wire logic                                fetch_en,
    input  wire logic [instr_decode_pkg::WORD_W-1:0] fetch_word,
    output logic      [instr_decode_pkg::WORD_W-1:0] word
);
    import instr_decode_pkg::*;
    // whole word fetched
    // outside a fetch the bus toggles every clock, so a stale word is back unchanged at the next cycle end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            word <= 14'h1555;
        else if (fetch_en)
            word <= fetch_word;
        else
            word <= ~word;
    end
endmodule : prog_fetch_model
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the instruction word decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import instr_decode_pkg::*;
    logic               MCLK = 1'b0;
    logic               RST = 1'b1;
    logic               skip_true = 1'b0;
    logic               fetch_en = 1'b0;
    logic [WORD_W-1:0]  fetch_word = '0;
    logic [WORD_W-1:0]  instr_word;
    decoded_s           decoded;
    logic [PHASE_W-1:0] cycle_phase;
    logic               cycle_end;
    logic               discard;
    logic [WORD_W-1:0]  cur_w = WORD_NOP;
    logic [WORD_W-1:0]  rnd_w;
    logic               cur_forced = 1'b0;
    int                 error_cnt = 0;
    int                 checks = 0;
    int                 seed = 52558;
    // six two-cycle words, each followed by a filler that must be dropped, then four single-cycle words
    logic [WORD_W-1:0]  corner [16] = '{14'h0b7f, 14'h0000, 14'h1c80, 14'h0000,
        14'h0008, 14'h0000, 14'h2abc, 14'h0000, 14'h3400, 14'h0000, 14'h0009,
        14'h0000, 14'h0064, 14'h0100, 14'h3fff, 14'h39a5};

    // 125 MHz clock
    always #4 MCLK = ~MCLK;

    prog_fetch_model fetch (.clk(MCLK), .rst(RST), .fetch_en(fetch_en),
        .fetch_word(fetch_word), .word(instr_word));

    instr_word_decoder dut (.MCLK(MCLK), .RST(RST), .INSTR_WORD(instr_word),
        .SKIP_TRUE(skip_true), .DECODED(decoded), .CYCLE_PHASE(cycle_phase),
        .CYCLE_END(cycle_end), .PREFETCH_DISCARD(discard));

    function automatic iclass_e exp_class(input logic [13:0] w);
        if (w[13])
            return CLASS_CTRL;
        if (w[12])
            return CLASS_BIT;
        return (w[11:7] == 5'h00) ? CLASS_CTRL : CLASS_BYTE;
    endfunction : exp_class

    function automatic logic exp_pc(input logic [13:0] w);
        return w[13:12] == 2'h2 || (w[13:12] == 2'h3 && w[11:10] == 2'h1)
            || w == 14'h0008 || w == 14'h0009;
    endfunction : exp_pc

    function automatic logic exp_skip(input logic [13:0] w);
        return (w[13:12] == 2'h0 && (w[11:8] == 4'hb || w[11:8] == 4'hf))
            || (w[13:12] == 2'h1 && w[11]);
    endfunction : exp_skip

    // operation code with literal don't-care bits cleared
    function automatic logic [3:0] exp_op(input logic [13:0] w);
        if (w[13:12] == 2'h1)
            return {2'h0, w[11:10]};
        if (w[13:12] == 2'h2)
            return {3'h0, w[11]};
        if (w[13:12] == 2'h0 || w[11:10] == 2'h2)
            return w[11:8];
        if (w[11] == 1'b0)
            return {w[11:10], 2'h0};
        return {w[11:9], 1'b0};
    endfunction : exp_op

    task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] got);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one instruction cycle: fetch w, give the skip result for the current word
    task automatic step(input logic [13:0] w, input logic s);
        logic    dis;
        iclass_e cls;
        dis = !cur_forced && (exp_pc(cur_w) || (exp_skip(cur_w) && s));
        cls = exp_class(w);
        // the fetch path registers the word, so it is handed over one edge early
        do @(negedge MCLK); while (cycle_phase !== 2'h1);
        @(posedge MCLK);
        fetch_en <= 1'b1;
        fetch_word <= w;
        @(negedge MCLK);
        chk("end_early", 14'h0, 14'(cycle_end));
        @(posedge MCLK);
        fetch_en <= 1'b0;
        skip_true <= s;
        @(negedge MCLK);
        chk("cycle_end", 14'h1, 14'(cycle_end));
        chk("discard", 14'(dis), 14'(discard));
        @(posedge MCLK);
        skip_true <= 1'($random(seed));
        @(negedge MCLK);
        chk("phase", 14'h0, 14'(cycle_phase));
        chk("forced_nop", 14'(dis), 14'(decoded.forced_nop));
        cur_forced = dis;
        if (!dis)
        begin
            cur_w = w;
            chk("word", w, decoded.word);
            chk("class", 14'(cls), 14'(decoded.iclass));
            chk("pc_change", 14'(exp_pc(w)), 14'(decoded.pc_change));
            chk("is_skip", 14'(exp_skip(w)), 14'(decoded.is_skip));
            if (cls != CLASS_CTRL)
                chk("file", 14'(w[6:0]), 14'(decoded.file_sel));
            if (cls == CLASS_BYTE)
                chk("dest", 14'(w[7]), 14'(decoded.dest));
            if (cls == CLASS_BIT)
                chk("bit", 14'(w[9:7]), 14'(decoded.bit_sel));
            if (w[13:12] == 2'h3)
                chk("literal", 14'(w[7:0]), 14'(decoded.literal));
            if (w[13:12] == 2'h2)
                chk("target", 14'(w[10:0]), 14'(decoded.target));
            chk("opcode", 14'(exp_op(w)), 14'(decoded.opcode));
            chk("is_jump", 14'(w[13:12] == 2'h2), 14'(decoded.is_jump));
        end
        else
            chk("nop_word", WORD_NOP, decoded.word);
    endtask : step

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    // main sequence: reset, corner words, random words
    initial
    begin
        repeat (8) @(posedge MCLK);
        chk("reset_word", 14'h0, decoded.word);
        RST <= 1'b0;
        foreach (corner[i])
            step(corner[i], 1'b1);
        $display("corner words done");
        repeat (200)
        begin
            rnd_w = 14'($random(seed));
            // misc control words kept to no-operation
            if (rnd_w[13:7] == 7'h00)
                rnd_w = WORD_NOP;
            step(rnd_w, 1'($random(seed)));
        end
        $display("random words done");
        tally_and_finish();
    end

    // watchdog against a hang
    initial
    begin
        #40000;
        error_cnt++;
        $display("[FAIL] watchdog expected done seen hang");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
